// ==== design/i2cs_start_gen.v ====
// Start-condition generator of a two-wire host port with a register port.
// Assumes a single 200 MHz clock mclk; bus pins are asynchronous inputs.
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "i2cs_defs.vh"
module i2cs_start_gen (
  input wire mclk,
  input wire rst_b,
  input wire [3:0] addr,
  input wire [7:0] wdata,
  input wire wr_en,
  input wire rd_en,
  output reg [7:0] rdata,
  input wire scl_in,
  input wire sda_in,
  output reg scl_out,
  output reg scl_oe_b,
  output reg sda_out,
  output reg sda_oe_b,
  output reg irq
);
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT1 = 2'h1;
  localparam ST_WAIT2 = 2'h2;
  reg rst_m_q;
  reg rst_s_q;
  wire rst_n;
  reg scl_m_q;
  reg scl_s_q;
  reg sda_m_q;
  reg sda_s_q;
  reg [1:0] st_q;
  reg [1:0] st_d;
  reg [6:0] cnt_q;
  reg [6:0] cnt_d;
  reg [7:0] con2_q;
  reg [7:0] con2_d;
  reg [6:0] baud_q;
  reg [7:0] buf_q;
  reg sdet_q;
  reg sdet_d;
  reg sda_low_q;
  reg sda_low_d;
  reg [2:0] irq_st_q;
  reg [2:0] irq_st_d;
  reg [2:0] mask_q;
  reg ev_bcl;
  reg ev_sdet;
  wire busy;
  wire ev_write_collision_flag;
  wire wr_con2;
  wire wr_buf;

  function sel;
    input [3:0] a;
    input [3:0] b;
    begin
      sel = (a == b);
    end
  endfunction

  assign rst_n = rst_s_q;
  assign busy = (st_q != ST_IDLE);
  assign wr_con2 = wr_en && sel(addr, `I2CS_ADDR_CON2);
  assign wr_buf = wr_en && sel(addr, `I2CS_ADDR_BUF);
  assign ev_write_collision_flag = wr_buf && busy;

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
      sda_m_q <= 1'b1;
      sda_s_q <= 1'b1;
    end else begin
      scl_m_q <= scl_in;
      scl_s_q <= scl_m_q;
      sda_m_q <= sda_in;
      sda_s_q <= sda_m_q;
    end
  end

  always @* begin
    st_d = st_q;
    cnt_d = cnt_q;
    con2_d = con2_q;
    sdet_d = sdet_q;
    sda_low_d = sda_low_q;
    ev_bcl = 1'b0;
    ev_sdet = 1'b0;
    if (wr_con2) begin
      if (busy) begin
        con2_d = (wdata & ~`I2CS_CON2_LOW_MASK) |
                 (con2_q & `I2CS_CON2_LOW_MASK);
      end else begin
        con2_d = wdata;
      end
    end
    case (st_q)
      ST_IDLE: begin
        if (con2_q[`I2CS_BIT_START]) begin
          if (!scl_s_q && !sda_s_q) begin
            ev_bcl = 1'b1;
            con2_d[`I2CS_BIT_START] = 1'b0;
          end else if (scl_s_q && sda_s_q) begin
            cnt_d = baud_q;
            sda_low_d = 1'b0;
            st_d = ST_WAIT1;
          end
        end
      end
      ST_WAIT1: begin
        if (!scl_s_q) begin
          ev_bcl = 1'b1;
          con2_d[`I2CS_BIT_START] = 1'b0;
          st_d = ST_IDLE;
        end else if (cnt_q == 7'h00) begin
          if (sda_s_q) begin
            sda_low_d = 1'b1;
            sdet_d = 1'b1;
            ev_sdet = 1'b1;
            cnt_d = baud_q;
            st_d = ST_WAIT2;
          end else begin
            ev_bcl = 1'b1;
            con2_d[`I2CS_BIT_START] = 1'b0;
            st_d = ST_IDLE;
          end
        end else begin
          cnt_d = cnt_q - 7'h01;
        end
      end
      ST_WAIT2: begin
        if (cnt_q == 7'h00) begin
          con2_d[`I2CS_BIT_START] = 1'b0;
          st_d = ST_IDLE;
        end else begin
          cnt_d = cnt_q - 7'h01;
        end
      end
      default: begin
        st_d = ST_IDLE;
      end
    endcase
    irq_st_d = irq_st_q;
    if (wr_en && sel(addr, `I2CS_ADDR_IRQ)) begin
      irq_st_d = irq_st_q & ~wdata[2:0];
    end
    if (ev_bcl) begin
      irq_st_d[`I2CS_IRQ_BCL] = 1'b1;
    end
    if (ev_write_collision_flag) begin
      irq_st_d[`I2CS_IRQ_WRITE_COLLISION_FLAG] = 1'b1;
    end
    if (ev_sdet) begin
      irq_st_d[`I2CS_IRQ_SDET] = 1'b1;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      cnt_q <= 7'h00;
      con2_q <= 8'h00;
      baud_q <= `I2CS_BAUD_RST;
      buf_q <= 8'h00;
      sdet_q <= 1'b0;
      sda_low_q <= 1'b0;
      irq_st_q <= 3'h0;
      mask_q <= 3'h0;
      rdata <= 8'h00;
      scl_out <= 1'b0;
      scl_oe_b <= 1'b1;
      sda_out <= 1'b0;
      sda_oe_b <= 1'b1;
      irq <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      con2_q <= con2_d;
      sdet_q <= sdet_d;
      sda_low_q <= sda_low_d;
      irq_st_q <= irq_st_d;
      if (wr_en && sel(addr, `I2CS_ADDR_BAUD)) begin
        baud_q <= wdata[6:0];
      end
      if (wr_en && sel(addr, `I2CS_ADDR_MASK)) begin
        mask_q <= wdata[2:0];
      end
      if (wr_buf && !busy) begin
        buf_q <= wdata;
      end
      scl_out <= 1'b0;
      scl_oe_b <= 1'b1;
      sda_out <= 1'b0;
      sda_oe_b <= ~sda_low_d;
      irq <= |(irq_st_d & mask_q);
      rdata <= 8'h00;
      if (rd_en) begin
        case (addr)
          `I2CS_ADDR_CON2: rdata <= con2_q;
          `I2CS_ADDR_STAT: rdata <= {4'h0, sdet_q, 3'h0};
          `I2CS_ADDR_BAUD: rdata <= {1'b0, baud_q};
          `I2CS_ADDR_BUF: rdata <= buf_q;
          `I2CS_ADDR_IRQ: rdata <= {5'h00, irq_st_q};
          `I2CS_ADDR_MASK: rdata <= {5'h00, mask_q};
          default: rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== design/i2cs_defs.vh ====
// Constants of the two-wire start generator: offsets, fields, reset values.
// Assumes inclusion by its bare name from the design file.
`ifndef I2CS_DEFS_VH
`define I2CS_DEFS_VH
`define I2CS_ADDR_CON2 4'h0
`define I2CS_ADDR_STAT 4'h1
`define I2CS_ADDR_BAUD 4'h2
`define I2CS_ADDR_BUF 4'h3
`define I2CS_ADDR_IRQ 4'h4
`define I2CS_ADDR_MASK 4'h5
`define I2CS_BIT_START 0
`define I2CS_BIT_SDET 3
`define I2CS_IRQ_BCL 0
`define I2CS_IRQ_WRITE_COLLISION_FLAG 1
`define I2CS_IRQ_SDET 2
`define I2CS_CON2_LOW_MASK 8'h1f
`define I2CS_BAUD_RST 7'h04
`endif

// ==== verif/i2cs_start_gen_props.sv ====
// Port checker of the start generator.
// Assumes it is bound to i2cs_start_gen.
`timescale 1ns/1ps
`default_nettype none
module i2cs_chk (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic rd_en,
  input wire logic [7:0] rdata,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic scl_out,
  input wire logic scl_oe_b,
  input wire logic sda_out,
  input wire logic sda_oe_b
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  chk_scl_free: assert property (scl_oe_b)
    else $error("scl pulled");
  chk_scl_zero: assert property (!scl_out)
    else $error("scl out high");
  chk_sda_zero: assert property (!sda_out)
    else $error("sda out high");
  chk_sda_cause: assert property ($fell(sda_oe_b) |->
    $past(sda_in, 3) && $past(scl_in, 3)) else $error("start early");
  chk_start_form: assert property ($fell(sda_oe_b) |-> scl_in)
    else $error("start scl low");
  chk_scl_before: assert property ($fell(sda_oe_b) |->
    $past(scl_in, 2) && $past(scl_in, 3)) else $error("start in clash");
  chk_sda_kept: assert property ($fell(sda_oe_b) |=> !sda_oe_b [*8])
    else $error("sda let go");
  chk_rd_quiet: assert property (!$past(rd_en) |-> rdata == 8'h00)
    else $error("stray rdata");
endmodule
bind i2cs_start_gen i2cs_chk u_chk (.mclk(mclk), .rst_b(rst_b),
  .rd_en(rd_en), .rdata(rdata), .scl_in(scl_in), .sda_in(sda_in),
  .scl_out(scl_out), .scl_oe_b(scl_oe_b), .sda_out(sda_out),
  .sda_oe_b(sda_oe_b));
`default_nettype wire

// ==== verif/i2cs_bus_peer.sv ====
// Wired-and bus with pull-ups and a second party.
// Assumes the bench sets hold_scl and hold_sda.
`timescale 1ns/1ps
`default_nettype none
module i2cs_bus_peer (
  input wire logic scl_oe_b,
  input wire logic sda_oe_b,
  input wire logic hold_scl,
  input wire logic hold_sda,
  output logic scl,
  output logic sda
);
  // A released line goes to the pull-up level.
  assign scl = !(hold_scl || !scl_oe_b);
  assign sda = !(hold_sda || !sda_oe_b);
endmodule
`default_nettype wire

// ==== verif/i2cs_start_gen_bench.sv ====
// Bench of the start generator.
// Assumes the design, checker and bus peer are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, w) begin n_compared++; if ((g) !== (w)) begin errors++; \
  $display("MISMATCH %0t got %h want %h", $time, g, w); end end
module i2cs_start_gen_bench;
  logic mclk = 0, rst_b = 0, wr_en = 0, rd_en = 0, h_scl = 0, h_sda = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  wire logic [7:0] rdata;
  wire logic scl, sda, scl_out, scl_oe_b, sda_out, sda_oe_b, irq;
  int errors = 0, n_compared = 0;
  always #2.5 mclk = ~mclk;
  i2cs_start_gen DUT (.mclk(mclk), .rst_b(rst_b), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .scl_in(scl), .sda_in(sda), .scl_out(scl_out), .scl_oe_b(scl_oe_b),
    .sda_out(sda_out), .sda_oe_b(sda_oe_b), .irq(irq));
  i2cs_bus_peer peer (.scl_oe_b(scl_oe_b), .sda_oe_b(sda_oe_b),
    .hold_scl(h_scl), .hold_sda(h_sda), .scl(scl), .sda(sda));
  task do_reset(input int n);
    rst_b <= 1'b0;
    repeat (n) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (4) @(posedge mclk);
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [7:0] w);
    @(posedge mclk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    `CHK(rdata, w)
  endtask
  task t_start;
    rd(4'h2, 8'h04);
    wr(4'h5, 8'h07);
    wr(4'h3, 8'haa);
    wr(4'h0, 8'h01);
    wr(4'h3, 8'h55);
    wr(4'h0, 8'h1e);
    repeat (20) @(posedge mclk);
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h08);
    rd(4'h3, 8'haa);
    rd(4'h4, 8'h06);
    `CHK(sda_oe_b, 1'b0)
    `CHK(irq, 1'b1)
    wr(4'h5, 8'h00);
    repeat (2) @(posedge mclk);
    `CHK(irq, 1'b0)
    wr(4'h4, 8'h07);
    rd(4'h4, 8'h00);
    $display("start test done");
  endtask
  task t_coll;
    do_reset(2);
    wr(4'h5, 8'h07);
    wr(4'h2, 8'h10);
    wr(4'h0, 8'h01);
    @(posedge mclk);
    h_scl <= 1'b1;
    repeat (10) @(posedge mclk);
    h_scl <= 1'b0;
    rd(4'h4, 8'h01);
    rd(4'h0, 8'h00);
    `CHK(sda_oe_b, 1'b1)
    @(posedge mclk);
    h_scl <= 1'b1;
    h_sda <= 1'b1;
    wr(4'h4, 8'h01);
    wr(4'h0, 8'h01);
    repeat (6) @(posedge mclk);
    rd(4'h4, 8'h01);
    rd(4'h1, 8'h00);
    `CHK(irq, 1'b1)
    @(posedge mclk);
    h_scl <= 1'b0;
    h_sda <= 1'b0;
    $display("collision test done");
  endtask
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    do_reset(16);
    t_start;
    t_coll;
    report_and_stop;
  end
  initial begin
    repeat (3000) @(posedge mclk);
    errors++;
    report_and_stop;
  end
endmodule
`default_nettype wire
